// [hw/nlch_pkg.sv]
// Constants and types shared by the loader command handler
package nlch_pkg;

  // Address map of the loader view
  localparam logic [31:0] NVM_BASE = 32'h1100_0000;
  localparam logic [31:0] STACK_INIT = 32'h1800_0400;
  localparam logic [31:0] LINK_CLEARED = 32'h0000_0000;
  localparam logic [24:0] NVM_CAPACITY = 25'h001_0000;
  localparam logic [24:0] EXEC_LIMIT = NVM_CAPACITY - 25'h000_0004;
  localparam logic [23:0] NONLIN_BASE = 24'h00_C000;
  localparam logic [7:0] PAGE_BYTES = 8'h80;
  localparam logic [7:0] PAGE_LAST = 8'h7F;
  localparam logic [7:0] MAX_COUNT = 8'h80;

  // Block lengths and message types
  localparam logic [7:0] LEN_WR = 8'h06;
  localparam logic [7:0] TYPE_WR = 8'h05;
  localparam logic [7:0] LEN_EX = 8'h04;
  localparam logic [7:0] TYPE_EX = 8'h86;
  localparam logic [7:0] LEN_RD = 8'h06;
  localparam logic [7:0] TYPE_RD = 8'h87;
  localparam logic [7:0] TYPE_TRAIL = 8'h80;
  localparam logic [7:0] RSP_LEN = 8'h02;
  localparam logic [7:0] TYPE_RSP = 8'h40;
  localparam logic [7:0] RSP_TOTAL = 8'h03;

  // Header byte positions, counted after the length byte
  localparam logic [7:0] POS_TYPE = 8'h00;
  localparam logic [7:0] POS_OFF_HI = 8'h01;
  localparam logic [7:0] POS_OFF_MID = 8'h02;
  localparam logic [7:0] POS_OFF_LO = 8'h03;
  localparam logic [7:0] POS_COUNT = 8'h05;

  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_PARAMS = 8'h01;
  localparam logic [7:0] ERR_ADDR_RANGE = 8'h02;
  localparam logic [7:0] ERR_PAGE_CROSS = 8'h03;
  localparam logic [7:0] ERR_NOT_MAPPED = 8'h04;
  localparam logic [7:0] ERR_DBE = 8'h05;
  localparam logic [7:0] ERR_RECV_MISMATCH = 8'h06;

  typedef enum logic [1:0] {CMD_NONE, CMD_WR, CMD_EX, CMD_RD} nlch_cmd_t;

  typedef enum logic [3:0] {
    S_IDLE, S_HDR, S_DEC, S_TLEN, S_TDATA, S_DEC_W, S_CHECK,
    S_RD, S_WR_LOAD, S_WR_PROG, S_RESP, S_SEND, S_JUMP, S_HALT
  } nlch_state_t;

endpackage : nlch_pkg

// [hw/nlch_page_buf.sv]
// One-page byte buffer with a per-byte supplied mask
`timescale 1ns/10ps
module nlch_page_buf (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Write side
  input logic clr,
  input logic wr_en,
  input logic wr_keep,
  input logic [6:0] wr_idx,
  input logic [7:0] wr_data,
  // Read side
  input logic [6:0] rd_idx,
  output logic [7:0] rd_data
);
  import nlch_pkg::*;

  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [127:0] mask;
  } nlch_buf_t;

  nlch_buf_t s;
  nlch_buf_t next_s;

  always_comb begin
    next_s = s;
    if (clr) begin
      next_s.mask = '0;
    end else if (wr_en) begin
      // Keep mode fills only bytes the host did not supply
      if (!wr_keep) begin
        next_s.mem[wr_idx] = wr_data;
        next_s.mask[wr_idx] = 1'b1;
      end else if (!s.mask[wr_idx]) begin
        next_s.mem[wr_idx] = wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.mem[rd_idx];

endmodule : nlch_page_buf

// [hw/nlch_checker.sv]
// Range, page and mapping checks on a decoded request
`timescale 1ns/10ps
module nlch_checker (
  // Request
  input nlch_pkg::nlch_cmd_t cmd,
  input logic [23:0] off,
  input logic [7:0] cnt,
  input logic mapped,
  // Verdict
  output logic [7:0] err
);
  import nlch_pkg::*;

  logic [24:0] end_off;
  logic [8:0] page_end;

  always_comb begin
    end_off = {1'b0, off} + {17'h0_0000, cnt};
    page_end = {2'b00, off[6:0]} + {1'b0, cnt};
    err = ERR_NONE;
    if (cmd == CMD_EX) begin
      if ({1'b0, off} > EXEC_LIMIT) begin
        err = ERR_ADDR_RANGE;
      end
    end else if (cnt == 8'h00 || cnt > MAX_COUNT) begin
      err = ERR_PARAMS;
    end else if ({1'b0, off} >= NVM_CAPACITY || end_off > NVM_CAPACITY) begin
      err = ERR_ADDR_RANGE;
    end else if (page_end > {1'b0, PAGE_BYTES}) begin
      // Write and read both stay inside one page
      err = ERR_PAGE_CROSS;
    end else if (cmd == CMD_RD && off >= NONLIN_BASE && !mapped) begin
      err = ERR_NOT_MAPPED;
    end
  end

endmodule : nlch_checker

// [hw/nlch_top.sv]
// Loader command handler: non-volatile write, execute and read
//
// Function
// - Write offset 24 bits, MSB first, from base
// - Count byte gives exact trailing bytes, max 128
// - Reject execute offset above capacity minus four
// - No code validity check before jumping
// - Set stack, PLL clock, clear irqs, watchdog
// - Return link cleared; only reset re-enters
// - Execute at once, reply only on error
// - Read header: offset, reserved, then count
// - Reject reads of unmapped non-linear pages
// - Double-bit check on every byte read
// - Reject page crossing or out-of-range reads
// - Read data returned in trailing block
// - Refuse page crossing writes, preserve other bytes
`timescale 1ns/10ps
module nlch_top (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Incoming byte stream
  input logic rx_valid,
  input logic [7:0] rx_data,
  output logic rx_ready,
  // Outgoing byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  input logic tx_ready,
  // Non-volatile memory port
  output logic nvm_req,
  output logic nvm_we,
  output logic [23:0] nvm_addr,
  output logic [7:0] nvm_wdata,
  input logic [7:0] nvm_rdata,
  input logic nvm_ack,
  input logic nvm_dbe,
  input logic nvm_page_mapped,
  // Hand-off to user code
  output logic jump_valid,
  output logic [31:0] jump_target,
  output logic [31:0] stack_pointer,
  output logic [31:0] return_link_register,
  output logic pll_select,
  output logic irq_clear,
  output logic wdt_enable
);
  import nlch_pkg::*;

  typedef struct packed {
    nlch_state_t st;
    nlch_cmd_t cmd;
    logic [7:0] len;
    logic [7:0] typ;
    logic [7:0] idx;
    logic [23:0] off;
    logic [7:0] cnt;
    logic [7:0] err;
    logic rsp_rd;
    logic [7:0] tx_idx;
    logic [7:0] tx_total;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic nvm_req;
    logic nvm_we;
    logic [23:0] nvm_addr;
    logic [7:0] nvm_wdata;
    logic jump;
    logic [31:0] jump_target;
    logic [31:0] sp;
    logic [31:0] ret_link;
    logic pll_sel;
    logic irq_clr;
    logic wdt_en;
  } nlch_top_t;

  nlch_top_t s;
  nlch_top_t next_s;
  logic take;
  logic [7:0] chk_err;
  logic buf_clr;
  logic buf_wr;
  logic buf_keep;
  logic [6:0] buf_widx;
  logic [7:0] buf_wdata;
  logic [6:0] buf_ridx;
  logic [7:0] buf_rdata;

  nlch_checker u_chk (
    .cmd(s.cmd),
    .off(s.off),
    .cnt(s.cnt),
    .mapped(nvm_page_mapped),
    .err(chk_err)
  );

  nlch_page_buf u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .clr(buf_clr),
    .wr_en(buf_wr),
    .wr_keep(buf_keep),
    .wr_idx(buf_widx),
    .wr_data(buf_wdata),
    .rd_idx(buf_ridx),
    .rd_data(buf_rdata)
  );

  assign take = rx_valid && s.rx_ready;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.jump = 1'b0;
    next_s.irq_clr = 1'b0;
    buf_clr = 1'b0;
    buf_wr = 1'b0;
    buf_keep = 1'b0;
    buf_widx = s.idx[6:0];
    buf_wdata = nvm_rdata;
    buf_ridx = (s.st == S_SEND) ? 7'(s.tx_idx - 8'h02) : s.idx[6:0];
    case (s.st)
      S_IDLE: begin
        // Zero length carries nothing to collect
        if (take && rx_data != 8'h00) begin
          next_s.len = rx_data;
          next_s.idx = 8'h00;
          next_s.err = ERR_NONE;
          next_s.st = S_HDR;
        end
      end
      S_HDR: begin
        if (take) begin
          case (s.idx)
            POS_TYPE: next_s.typ = rx_data;
            POS_OFF_HI: next_s.off[23:16] = rx_data;
            POS_OFF_MID: next_s.off[15:8] = rx_data;
            POS_OFF_LO: next_s.off[7:0] = rx_data;
            POS_COUNT: next_s.cnt = rx_data;
            default: next_s.cnt = s.cnt;
          endcase
          next_s.idx = s.idx + 8'h01;
          if (s.idx + 8'h01 == s.len) begin
            next_s.st = S_DEC;
          end
        end
      end
      S_DEC: begin
        next_s.nvm_addr = s.off;
        if (s.typ == TYPE_WR && s.len == LEN_WR) begin
          next_s.cmd = CMD_WR;
          buf_clr = 1'b1;
          next_s.st = S_TLEN;
        end else if (s.typ == TYPE_RD && s.len == LEN_RD) begin
          next_s.cmd = CMD_RD;
          next_s.st = S_CHECK;
        end else if (s.typ == TYPE_EX && s.len == LEN_EX) begin
          next_s.cmd = CMD_EX;
          next_s.st = S_CHECK;
        end else begin
          next_s.cmd = CMD_NONE;
          next_s.err = ERR_PARAMS;
          next_s.st = S_RESP;
        end
      end
      S_TLEN: begin
        if (take) begin
          next_s.len = rx_data;
          next_s.idx = 8'h00;
          next_s.st = S_TDATA;
          if (rx_data == 8'h00) begin
            next_s.err = ERR_RECV_MISMATCH;
            next_s.st = S_RESP;
          end
        end
      end
      S_TDATA: begin
        if (take) begin
          if (s.idx == POS_TYPE) begin
            if (rx_data != TYPE_TRAIL) begin
              next_s.err = ERR_RECV_MISMATCH;
            end
          end else begin
            // Data lands at its page position so unsent bytes survive
            buf_wr = 1'b1;
            buf_widx = 7'(s.off[6:0] + s.idx[6:0] - 7'h01);
            buf_wdata = rx_data;
          end
          next_s.idx = s.idx + 8'h01;
          if (s.idx + 8'h01 == s.len) begin
            next_s.st = S_DEC_W;
          end
        end
      end
      S_DEC_W: begin
        // Whole block is absorbed before any verdict, keeping the link in step
        if (s.err == ERR_NONE && s.len != s.cnt + 8'h01) begin
          next_s.err = ERR_RECV_MISMATCH;
        end
        next_s.st = (s.err == ERR_NONE && s.len == s.cnt + 8'h01) ? S_CHECK : S_RESP;
      end
      S_CHECK: begin
        next_s.idx = 8'h00;
        if (chk_err != ERR_NONE) begin
          next_s.err = chk_err;
          next_s.st = S_RESP;
        end else if (s.cmd == CMD_EX) begin
          next_s.st = S_JUMP;
        end else if (s.cmd == CMD_RD) begin
          next_s.st = S_RD;
        end else begin
          next_s.st = S_WR_LOAD;
        end
      end
      S_RD: begin
        if (nvm_ack) begin
          next_s.nvm_req = 1'b0;
          buf_wr = 1'b1;
          if (nvm_dbe) begin
            next_s.err = ERR_DBE;
            next_s.st = S_RESP;
          end else if (s.idx + 8'h01 == s.cnt) begin
            next_s.rsp_rd = 1'b1;
            next_s.tx_total = s.cnt + 8'h02;
            next_s.tx_idx = 8'h00;
            next_s.st = S_SEND;
          end else begin
            next_s.idx = s.idx + 8'h01;
          end
        end else if (!s.nvm_req) begin
          next_s.nvm_req = 1'b1;
          next_s.nvm_we = 1'b0;
          next_s.nvm_addr = s.off + {16'h0000, s.idx};
        end
      end
      S_WR_LOAD: begin
        // Read-modify-write of the full page
        if (nvm_ack) begin
          next_s.nvm_req = 1'b0;
          buf_wr = 1'b1;
          buf_keep = 1'b1;
          if (nvm_dbe) begin
            next_s.err = ERR_DBE;
            next_s.st = S_RESP;
          end else if (s.idx == PAGE_LAST) begin
            next_s.idx = 8'h00;
            next_s.st = S_WR_PROG;
          end else begin
            next_s.idx = s.idx + 8'h01;
          end
        end else if (!s.nvm_req) begin
          next_s.nvm_req = 1'b1;
          next_s.nvm_we = 1'b0;
          next_s.nvm_addr = {s.off[23:7], s.idx[6:0]};
        end
      end
      S_WR_PROG: begin
        if (nvm_ack) begin
          next_s.nvm_req = 1'b0;
          next_s.nvm_we = 1'b0;
          if (s.idx == PAGE_LAST) begin
            next_s.err = ERR_NONE;
            next_s.st = S_RESP;
          end else begin
            next_s.idx = s.idx + 8'h01;
          end
        end else if (!s.nvm_req) begin
          next_s.nvm_req = 1'b1;
          next_s.nvm_we = 1'b1;
          next_s.nvm_addr = {s.off[23:7], s.idx[6:0]};
          next_s.nvm_wdata = buf_rdata;
        end
      end
      S_RESP: begin
        next_s.rsp_rd = 1'b0;
        next_s.tx_total = RSP_TOTAL;
        next_s.tx_idx = 8'h00;
        next_s.st = S_SEND;
      end
      S_SEND: begin
        if (!s.tx_valid || tx_ready) begin
          if (s.tx_idx == s.tx_total) begin
            next_s.tx_valid = 1'b0;
            // A stale read flag would mislabel the next command's error path
            next_s.rsp_rd = 1'b0;
            next_s.st = S_IDLE;
          end else begin
            next_s.tx_valid = 1'b1;
            next_s.tx_idx = s.tx_idx + 8'h01;
            if (s.rsp_rd) begin
              case (s.tx_idx)
                8'h00: next_s.tx_data = s.cnt + 8'h01;
                8'h01: next_s.tx_data = TYPE_TRAIL;
                default: next_s.tx_data = buf_rdata;
              endcase
            end else begin
              case (s.tx_idx)
                8'h00: next_s.tx_data = RSP_LEN;
                8'h01: next_s.tx_data = TYPE_RSP;
                default: next_s.tx_data = s.err;
              endcase
            end
          end
        end
      end
      S_JUMP: begin
        next_s.sp = STACK_INIT;
        next_s.ret_link = LINK_CLEARED;
        next_s.jump_target = NVM_BASE + {8'h00, s.off};
        next_s.pll_sel = 1'b1;
        next_s.irq_clr = 1'b1;
        next_s.wdt_en = 1'b1;
        next_s.jump = 1'b1;
        next_s.st = S_HALT;
      end
      // Only a reset leaves this state
      default: next_s.st = S_HALT;
    endcase
    next_s.rx_ready = (next_s.st == S_IDLE) || (next_s.st == S_HDR) ||
                      (next_s.st == S_TLEN) || (next_s.st == S_TDATA);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rx_ready = s.rx_ready;
  assign tx_valid = s.tx_valid;
  assign tx_data = s.tx_data;
  assign nvm_req = s.nvm_req;
  assign nvm_we = s.nvm_we;
  assign nvm_addr = s.nvm_addr;
  assign nvm_wdata = s.nvm_wdata;
  assign jump_valid = s.jump;
  assign jump_target = s.jump_target;
  assign stack_pointer = s.sp;
  assign return_link_register = s.ret_link;
  assign pll_select = s.pll_sel;
  assign irq_clear = s.irq_clr;
  assign wdt_enable = s.wdt_en;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_HDR_OFF_MSB: assert property (
    s.st == S_HDR && take && s.idx == POS_OFF_HI |=> s.off[23:16] == $past(rx_data))
    else $error("offset high byte not captured");
  AST_WR_COUNT: assert property (
    s.st == S_DEC_W && s.err == ERR_NONE && s.len != s.cnt + 8'h01 |=> s.st == S_RESP && s.err == ERR_RECV_MISMATCH)
    else $error("trailing length mismatch not reported");
  AST_EXEC_RANGE: assert property (
    $rose(s.jump) |-> {1'b0, s.jump_target - NVM_BASE} <= {8'h00, EXEC_LIMIT})
    else $error("jump beyond execute limit");
  AST_EXEC_SETUP: assert property (
    $rose(s.jump) |-> s.sp == STACK_INIT && s.pll_sel && s.irq_clr && s.wdt_en)
    else $error("jump setup incomplete");
  AST_EXEC_LINK: assert property (
    $rose(s.jump) |-> s.ret_link == LINK_CLEARED ##1 (s.st == S_HALT && !s.rx_ready) [*3])
    else $error("loader not sealed after jump");
  AST_EXEC_NOW: assert property (
    s.st == S_CHECK && s.cmd == CMD_EX && chk_err == ERR_NONE |=> ##1 s.jump && !s.tx_valid)
    else $error("execute not immediate or replied");
  AST_UNMAPPED: assert property (
    s.st == S_CHECK && s.cmd == CMD_RD && chk_err == ERR_NOT_MAPPED |=> s.err == ERR_NOT_MAPPED ##1 s.st == S_SEND)
    else $error("unmapped read not rejected");
  AST_DBE: assert property (
    s.st == S_RD && nvm_ack && nvm_dbe |=> s.st == S_RESP && s.err == ERR_DBE && !s.rsp_rd)
    else $error("double-bit error not reported");
  AST_RD_BLOCK: assert property (
    s.st == S_SEND && s.rsp_rd && s.tx_idx == 8'h01 && s.tx_valid |-> s.tx_data == s.cnt + 8'h01)
    else $error("read block length wrong");
  AST_NO_WRITE_ON_ERR: assert property (
    s.nvm_req && s.nvm_we |-> s.cmd == CMD_WR && s.err == ERR_NONE && s.st == S_WR_PROG)
    else $error("memory written on a rejected request");
  AST_ONE_CODE: assert property (
    s.st == S_RESP |=> s.st == S_SEND && s.tx_total == RSP_TOTAL && !s.rsp_rd)
    else $error("error response malformed");

endmodule : nlch_top

// [sim/nlch_nvm_model.sv]
// Byte-wide memory model on the handler's memory port, with stall, fault and mapping knobs
`timescale 1ns/10ps
module nlch_nvm_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Memory port
  input wire logic nvm_req,
  input wire logic nvm_we,
  input wire logic [23:0] nvm_addr,
  input wire logic [7:0] nvm_wdata,
  output logic [7:0] nvm_rdata,
  output logic nvm_ack,
  output logic nvm_dbe,
  output logic nvm_page_mapped,
  // Bench controls
  input wire logic slow,
  input wire logic [23:0] dbe_addr,
  input wire logic [16:0] unmapped_page
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end

  assign nvm_page_mapped = (nvm_addr[23:7] != unmapped_page);

  ////////////////////////////////////////////////////////////////////////////
  // Plain always: memory also written by the initial preload
  always @(posedge clk) begin
    if (!rst_n) begin
      nvm_ack <= 1'b0;
      nvm_dbe <= 1'b0;
      nvm_rdata <= 8'h00;
      wait_cnt <= 2'h0;
    end else if (nvm_req && !nvm_ack && wait_cnt == (slow ? 2'h3 : 2'h0)) begin
      nvm_ack <= 1'b1;
      wait_cnt <= 2'h0;
      nvm_rdata <= mem[nvm_addr[15:0]];
      nvm_dbe <= (nvm_addr == dbe_addr) && !nvm_we;
      if (nvm_we) begin
        mem[nvm_addr[15:0]] <= nvm_wdata;
      end
    end else begin
      nvm_ack <= 1'b0;
      nvm_dbe <= 1'b0;
      // Stale read data is scrambled so nothing relies on it
      nvm_rdata <= ~nvm_rdata;
      wait_cnt <= (nvm_req && !nvm_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : nlch_nvm_model

// [sim/nlch_top_tb.sv]
// Self-checking bench for the loader command handler
`timescale 1ns/10ps
module nlch_top_tb;
  import nlch_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic tx_ready = 1'b1;
  logic slow = 1'b0;
  logic [23:0] dbe_addr = 24'hFFFFFF;
  logic rx_ready, tx_valid, nvm_req, nvm_we, nvm_ack, nvm_dbe, nvm_page_mapped;
  logic jump_valid, pll_select, irq_clear, wdt_enable;
  logic [7:0] tx_data, nvm_wdata, nvm_rdata;
  logic [23:0] nvm_addr;
  logic [31:0] jump_target, stack_pointer, return_link_register;
  int bad_count = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  nlch_top u_nlch_top (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .nvm_req(nvm_req), .nvm_we(nvm_we),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack), .nvm_dbe(nvm_dbe),
    .nvm_page_mapped(nvm_page_mapped), .jump_valid(jump_valid), .jump_target(jump_target),
    .stack_pointer(stack_pointer), .return_link_register(return_link_register), .pll_select(pll_select),
    .irq_clear(irq_clear), .wdt_enable(wdt_enable));

  nlch_nvm_model u_nlch_nvm_model (.clk(clk), .rst_n(rst_n), .nvm_req(nvm_req), .nvm_we(nvm_we),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack), .nvm_dbe(nvm_dbe),
    .nvm_page_mapped(nvm_page_mapped), .slow(slow), .dbe_addr(dbe_addr), .unmapped_page(17'h00180));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction : pat

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // Each byte is held until an edge sees rx_ready high
  task automatic send(input logic [7:0] b[$]);
    int n;
    @(posedge clk);
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_data <= b[i];
      n = 0;
      do begin @(posedge clk); n++; end while (rx_ready !== 1'b1 && n < 2000);
      check("byte taken", rx_ready, 1'b1);
    end
    rx_valid <= 1'b0;
  endtask : send

  task automatic recv(input string what, input logic [7:0] exp);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 2000);
    // Far shorter than the host's 8 ms; a late reply counts as overdue
    check({what, " wait"}, {31'h0, tx_valid === 1'b1 && tx_ready === 1'b1}, 32'h1);
    check(what, tx_data, exp);
  endtask : recv

  task automatic expect_code(input logic [7:0] code);
    recv("rsp len", RSP_LEN);
    recv("rsp type", TYPE_RSP);
    recv("rsp code", code);
  endtask : expect_code

  task automatic rd(input logic [23:0] off, input logic [7:0] cnt);
    send('{LEN_RD, TYPE_RD, off[23:16], off[15:8], off[7:0], 8'h00, cnt});
  endtask : rd

  task automatic wr(input logic [23:0] off, input logic [7:0] cnt, input logic [7:0] tlen, input logic [7:0] d[$]);
    logic [7:0] q[$];
    send('{LEN_WR, TYPE_WR, off[23:16], off[15:8], off[7:0], 8'h00, cnt});
    q = {tlen, TYPE_TRAIL, d};
    send(q);
  endtask : wr

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write_read;
    wr(24'h000105, 8'h02, 8'h03, '{8'hA1, 8'hB2});
    expect_code(ERR_NONE);
    slow <= 1'b1;
    rd(24'h000104, 8'h04);
    tx_ready <= 1'b0;
    repeat (80) @(posedge clk);
    check("tx held", tx_valid, 1'b1);
    tx_ready <= 1'b1;
    recv("rd len", 8'h05);
    recv("rd type", TYPE_TRAIL);
    recv("rd d0", pat(24'h000104));
    recv("rd d1", 8'hA1);
    recv("rd d2", 8'hB2);
    recv("rd d3", pat(24'h000107));
    slow <= 1'b0;
    $display("test write_read ended");
  endtask : t_write_read

  task automatic t_read_errors;
    logic [23:0] offs [6] = '{24'h000000, 24'h000000, 24'h00FFFF, 24'h010000, 24'h00007F, 24'h00C000};
    logic [7:0] cnts [6] = '{8'h00, 8'h81, 8'h02, 8'h01, 8'h02, 8'h01};
    logic [7:0] codes [6] = '{ERR_PARAMS, ERR_PARAMS, ERR_ADDR_RANGE, ERR_ADDR_RANGE, ERR_PAGE_CROSS, ERR_NOT_MAPPED};
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], cnts[i]);
      expect_code(codes[i]);
    end
    dbe_addr <= 24'h000202;
    rd(24'h000200, 8'h04);
    expect_code(ERR_DBE);
    dbe_addr <= 24'hFFFFFF;
    rd(24'h00C080, 8'h01);
    recv("nl len", 8'h02);
    recv("nl type", TYPE_TRAIL);
    recv("nl d0", pat(24'h00C080));
    $display("test read_errors ended");
  endtask : t_read_errors

  task automatic t_write_refused;
    wr(24'h00017F, 8'h02, 8'h03, '{8'h11, 8'h22});
    expect_code(ERR_PAGE_CROSS);
    wr(24'h000300, 8'h02, 8'h02, '{8'h33});
    expect_code(ERR_RECV_MISMATCH);
    send('{8'h05, TYPE_RD, 8'h00, 8'h00, 8'h00, 8'h01});
    expect_code(ERR_PARAMS);
    rd(24'h00017F, 8'h01);
    recv("kept len", 8'h02);
    recv("kept type", TYPE_TRAIL);
    recv("kept d0", pat(24'h00017F));
    $display("test write_refused ended");
  endtask : t_write_refused

  task automatic t_exec;
    int n;
    send('{LEN_EX, TYPE_EX, 8'h00, 8'hFF, 8'hFD});
    expect_code(ERR_ADDR_RANGE);
    check("sp before", stack_pointer, 32'h0);
    send('{LEN_EX, TYPE_EX, 8'h00, 8'hFF, 8'hFC});
    n = 0;
    do begin @(posedge clk); n++; end while (jump_valid !== 1'b1 && n < 50);
    check("jump seen", jump_valid, 1'b1);
    check("jump delay", n, 4);
    check("jump target", jump_target, NVM_BASE + 32'h0000FFFC);
    check("stack", stack_pointer, STACK_INIT);
    check("link", return_link_register, LINK_CLEARED);
    check("irq clear", irq_clear, 1'b1);
    check("pll", pll_select, 1'b1);
    check("wdt", wdt_enable, 1'b1);
    check("no reply", tx_valid, 1'b0);
    repeat (8) begin
      @(posedge clk);
      check("jump pulse", jump_valid, 1'b0);
      check("rx closed", rx_ready, 1'b0);
      check("link kept", return_link_register, LINK_CLEARED);
    end
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(24'h000104, 8'h01);
    recv("re len", 8'h02);
    recv("re type", TYPE_TRAIL);
    recv("re d0", pat(24'h000104));
    $display("test exec ended");
  endtask : t_exec

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_write_read;
    t_read_errors;
    t_write_refused;
    t_exec;
    wrap_up;
  end

  // Whole run needs well under 10k cycles; this leaves a wide margin
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    wrap_up;
  end
endmodule : nlch_top_tb
